// File: hw/p2mx_consts.svh
// constants for the port two pin multiplexer: offsets, fields, resets
//
// Contract
// - latch plus per-bit direction, one bit each
// - pins shared with segment, sar, delta-sigma, reference; the port has no reference connection
// - segment select overrides analog and direction
// - digital input needs port, digital, input
// - drive latch only for port, digital, output
// - analog unselected stays idle; analog output prohibited
// - sar-only selected analog pin feeds sar
// - ds-only pin feeds pair n; both prohibited
`ifndef P2MX_CONSTS_SVH
`define P2MX_CONSTS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define P2MX_OFS_LATCH   8'h00
`define P2MX_OFS_DIR     8'h04
`define P2MX_OFS_SEG     8'h08
`define P2MX_OFS_ANA     8'h0C
`define P2MX_OFS_SAR     8'h10
`define P2MX_OFS_DS      8'h14
`define P2MX_OFS_PINS    8'h18
`define P2MX_OFS_ERR     8'h1C

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define P2MX_RST_LATCH   8'h00
`define P2MX_RST_DIR     8'hFF
`define P2MX_RST_SEG     8'h00
`define P2MX_RST_ANA     8'hFF
`define P2MX_RST_SAR     4'h0
`define P2MX_RST_DS      3'h0

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define P2MX_SAR_EN_BIT  3
`define P2MX_DS_EN_BIT   2
`define P2MX_DS_PAIRS    2'h3

`endif

// File: hw/p2mx_pkg.sv
// types shared by the port two pin multiplexer files
package p2mx_pkg;

  // -----------------------------------------------------------------
  // software configuration carried as one bundle
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_two_output_latch;
    logic [7:0] port_two_direction_reg;       // 1 = input
    logic [7:0] port_two_segment_select_reg;  // 1 = segment
    logic [7:0] analog_digital_pin_config;    // 1 = analog
    logic [3:0] sar_channel_select;           // [3] enable, [2:0] pin
    logic [2:0] delta_sigma_input_control;    // [2] enable, [1:0] pair
  } p2mx_cfg_t;

  // -----------------------------------------------------------------
  // what a single pin does
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    P2MX_FN_SEG     = 3'h0,
    P2MX_FN_DIN     = 3'h1,
    P2MX_FN_DOUT    = 3'h2,
    P2MX_FN_ANA     = 3'h3,
    P2MX_FN_SAR     = 3'h4,
    P2MX_FN_DS      = 3'h5,
    P2MX_FN_BAD_OUT = 3'h6,
    P2MX_FN_BAD_BTH = 3'h7
  } p2mx_func_t;

endpackage : p2mx_pkg

// File: hw/p2mx_sync.sv
// three-stage input synchroniser with agreement filter for the pins
`timescale 1ns/100ps
module p2mx_sync (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // pins in, filtered levels out
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;

  // first stage is read only by the second to keep metastability contained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 8'h00;
      stage2 <= 8'h00;
      stage3 <= 8'h00;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule : p2mx_sync

// File: hw/p2mx_pin_decode.sv
// per-pin function decode from the software configuration
`timescale 1ns/100ps
`include "p2mx_consts.svh"
module p2mx_pin_decode (
  // configuration in
  input  wire p2mx_pkg::p2mx_cfg_t  cfg,
  // one function code per pin
  output p2mx_pkg::p2mx_func_t      func [8]
);

  // pin index picked by the sar channel field
  function automatic logic sar_hit(input logic [3:0] sel,
                                   input logic [2:0] pin);
    sar_hit = sel[`P2MX_SAR_EN_BIT] && (sel[2:0] == pin);
  endfunction : sar_hit

  // delta-sigma pair n covers pins 2n and 2n+1
  function automatic logic ds_hit(input logic [2:0] ctl,
                                  input logic [2:0] pin);
    ds_hit = ctl[`P2MX_DS_EN_BIT] && (ctl[1:0] != `P2MX_DS_PAIRS)
             && (ctl[1:0] == pin[2:1]);
  endfunction : ds_hit

  // priority: segment, then digital/analog, then direction, then channels
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic       s;
      logic       d;
      logic [2:0] p;
      p = 3'(i);
      s = sar_hit(cfg.sar_channel_select, p);
      d = ds_hit(cfg.delta_sigma_input_control, p);
      if (cfg.port_two_segment_select_reg[i]) begin
        func[i] = p2mx_pkg::P2MX_FN_SEG;
      end else if (!cfg.analog_digital_pin_config[i]) begin
        func[i] = cfg.port_two_direction_reg[i] ?
                  p2mx_pkg::P2MX_FN_DIN :
                  p2mx_pkg::P2MX_FN_DOUT;
      end else if (!cfg.port_two_direction_reg[i]) begin
        func[i] = p2mx_pkg::P2MX_FN_BAD_OUT;
      end else if (s && d) begin
        func[i] = p2mx_pkg::P2MX_FN_BAD_BTH;
      end else if (d) begin
        func[i] = p2mx_pkg::P2MX_FN_DS;
      end else if (s) begin
        func[i] = p2mx_pkg::P2MX_FN_SAR;
      end else begin
        func[i] = p2mx_pkg::P2MX_FN_ANA;
      end
    end
  end

endmodule : p2mx_pin_decode

// File: hw/p2mx_port.sv
// port two pin multiplexer: registers, pin steering and apb slave
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "p2mx_consts.svh"
module p2mx_port (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // the eight pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  // lcd segment driver
  input  wire logic [7:0]  lcd_segment_output,
  output logic      [7:0]  seg_pin_sel,
  // converters
  output logic      [7:0]  pin_analog_mode,
  output logic      [7:0]  sar_analog_input,
  output logic      [7:0]  delta_sigma_diff_pair
);

  // -----------------------------------------------------------------
  // configuration state
  // -----------------------------------------------------------------
  p2mx_pkg::p2mx_cfg_t  cfg;
  p2mx_pkg::p2mx_func_t func [8];
  logic [7:0]           pin_sync;
  logic [7:0]           err_out;
  logic [7:0]           err_both;
  logic [7:0]           pin_view;
  logic                 setup;
  logic                 access;
  logic                 wr_go;
  logic                 mapped;
  logic [31:0]          next_rdata;

  // bus phases: any request not yet answered gets pready next cycle;
  // keying on psel alone means a setup cycle lost to a ce stall is
  // still answered once the enable returns
  assign setup  = psel && !pready;
  assign access = psel && penable && pready;
  assign wr_go  = access && pwrite && pstrb[0];

  // only aligned words at the eight offsets exist
  always_comb begin
    case (paddr)
      `P2MX_OFS_LATCH, `P2MX_OFS_DIR, `P2MX_OFS_SEG, `P2MX_OFS_ANA,
      `P2MX_OFS_SAR, `P2MX_OFS_DS, `P2MX_OFS_PINS,
      `P2MX_OFS_ERR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // input synchroniser and function decode
  // -----------------------------------------------------------------
  p2mx_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  p2mx_pin_decode u_decode (
    .cfg  (cfg),
    .func (func)
  );

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------

  // output latch keeps its value whatever the pin does at the moment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.port_two_output_latch <= `P2MX_RST_LATCH;
    end else if (ce && wr_go && paddr == `P2MX_OFS_LATCH) begin
      cfg.port_two_output_latch <= pwdata[7:0];
    end
  end

  // direction bits: every pin an input after reset, so nothing drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.port_two_direction_reg <= `P2MX_RST_DIR;
    end else if (ce && wr_go && paddr == `P2MX_OFS_DIR) begin
      cfg.port_two_direction_reg <= pwdata[7:0];
    end
  end

  // segment select per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.port_two_segment_select_reg <= `P2MX_RST_SEG;
    end else if (ce && wr_go && paddr == `P2MX_OFS_SEG) begin
      cfg.port_two_segment_select_reg <= pwdata[7:0];
    end
  end

  // analog/digital choice per pin; analog after reset keeps buffers off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.analog_digital_pin_config <= `P2MX_RST_ANA;
    end else if (ce && wr_go && paddr == `P2MX_OFS_ANA) begin
      cfg.analog_digital_pin_config <= pwdata[7:0];
    end
  end

  // converter channel selections
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.sar_channel_select        <= `P2MX_RST_SAR;
      cfg.delta_sigma_input_control <= `P2MX_RST_DS;
    end else if (ce && wr_go) begin
      if (paddr == `P2MX_OFS_SAR) begin
        cfg.sar_channel_select <= pwdata[3:0];
      end
      if (paddr == `P2MX_OFS_DS) begin
        cfg.delta_sigma_input_control <= pwdata[2:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // pin steering, registered so every pin output comes from a flop
  // -----------------------------------------------------------------

  // one cycle from a register write to the pins; no glitch on the pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out               <= 8'h00;
      pin_oe                <= 8'h00;
      seg_pin_sel           <= 8'h00;
      pin_analog_mode       <= 8'hFF;
      sar_analog_input      <= 8'h00;
      delta_sigma_diff_pair <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        pin_out[i]               <= 1'b0;
        pin_oe[i]                <= 1'b0;
        seg_pin_sel[i]           <= 1'b0;
        pin_analog_mode[i]       <= 1'b0;
        sar_analog_input[i]      <= 1'b0;
        delta_sigma_diff_pair[i] <= 1'b0;
        case (func[i])
          p2mx_pkg::P2MX_FN_SEG: begin
            // segment driver owns the pad outright
            seg_pin_sel[i] <= 1'b1;
            pin_out[i]     <= lcd_segment_output[i];
            pin_oe[i]      <= 1'b1;
          end
          p2mx_pkg::P2MX_FN_DOUT: begin
            pin_out[i] <= cfg.port_two_output_latch[i];
            pin_oe[i]  <= 1'b1;
          end
          p2mx_pkg::P2MX_FN_DIN: begin
            pin_oe[i] <= 1'b0;
          end
          p2mx_pkg::P2MX_FN_SAR: begin
            pin_analog_mode[i]  <= 1'b1;
            sar_analog_input[i] <= 1'b1;
          end
          p2mx_pkg::P2MX_FN_DS: begin
            pin_analog_mode[i]       <= 1'b1;
            delta_sigma_diff_pair[i] <= 1'b1;
          end
          default: begin
            // idle analog and both prohibited settings: pad left
            // floating in analog mode, neither converter connected
            pin_analog_mode[i] <= 1'b1;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // readback of pin state and prohibited settings
  // -----------------------------------------------------------------

  // digital inputs show the filtered pad, outputs show the latch
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (func[i])
        p2mx_pkg::P2MX_FN_DIN: begin
          pin_view[i] = pin_sync[i];
        end
        p2mx_pkg::P2MX_FN_DOUT: begin
          pin_view[i] = cfg.port_two_output_latch[i];
        end
        default: begin
          pin_view[i] = 1'b0;
        end
      endcase
      err_out[i]  = (func[i] == p2mx_pkg::P2MX_FN_BAD_OUT);
      err_both[i] = (func[i] == p2mx_pkg::P2MX_FN_BAD_BTH);
    end
  end

  // read mux, sampled in the setup cycle so prdata is a flop
  always_comb begin
    case (paddr)
      `P2MX_OFS_LATCH: begin
        next_rdata = {24'h000000, cfg.port_two_output_latch};
      end
      `P2MX_OFS_DIR: begin
        next_rdata = {24'h000000, cfg.port_two_direction_reg};
      end
      `P2MX_OFS_SEG: begin
        next_rdata = {24'h000000, cfg.port_two_segment_select_reg};
      end
      `P2MX_OFS_ANA: begin
        next_rdata = {24'h000000, cfg.analog_digital_pin_config};
      end
      `P2MX_OFS_SAR: begin
        next_rdata = {28'h0000000, cfg.sar_channel_select};
      end
      `P2MX_OFS_DS: begin
        next_rdata = {29'h00000000, cfg.delta_sigma_input_control};
      end
      `P2MX_OFS_PINS: begin
        next_rdata = {24'h000000, pin_view};
      end
      `P2MX_OFS_ERR: begin
        next_rdata = {16'h0000, err_both, err_out};
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // apb answer: pready rises in the setup cycle, one access cycle
  // -----------------------------------------------------------------

  // read data is captured at setup; a write in the same access shows
  // up on the next read, never in this one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      if (setup) begin
        pready  <= 1'b1;
        pslverr <= !mapped;
        prdata  <= (pwrite || !mapped) ? 32'h00000000 : next_rdata;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

endmodule : p2mx_port

// File: tb/p2mx_port_properties.sv
// concurrent checks on the ports of the port two pin multiplexer
`timescale 1ns/100ps
module p2mx_port_properties (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin steering
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  lcd_segment_output,
  input wire logic [7:0]  seg_pin_sel,
  input wire logic [7:0]  pin_analog_mode,
  input wire logic [7:0]  sar_analog_input,
  input wire logic [7:0]  delta_sigma_diff_pair
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb steps: a setup seen with the enable high, then a one-cycle answer
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_answer; pready ##1 !pready; endsequence

  property p_ready_once; s_setup |=> s_answer; endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("answer not exactly one cycle");
  property p_unmapped;
    s_setup ##0 (paddr > 8'h1C) |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_seg_drive; (seg_pin_sel & ~pin_oe) == 8'h00; endproperty
  a_seg_drive: assert property (p_seg_drive)
    else $error("segment pin not driven");
  // pad copies the segment data one edge late, as the drive is registered;
  // a frozen cycle holds the old drive, so it is skipped
  property p_seg_data;
    $past(ce) |-> ((pin_out ^ $past(lcd_segment_output)) & seg_pin_sel
      & $past(seg_pin_sel)) == 8'h00;
  endproperty
  a_seg_data: assert property (p_seg_data)
    else $error("segment data not on pin");
  property p_dout_dig;
    (pin_oe & ~seg_pin_sel & pin_analog_mode) == 8'h00;
  endproperty
  a_dout_dig: assert property (p_dout_dig)
    else $error("analog pin driven");
  property p_sar_route;
    $onehot0(sar_analog_input) && (sar_analog_input
      & ~(pin_analog_mode & ~seg_pin_sel & ~pin_oe)) == 8'h00;
  endproperty
  a_sar_route: assert property (p_sar_route)
    else $error("sar routed to a non-analog pin");
  property p_ds_route;
    (delta_sigma_diff_pair & (sar_analog_input
      | ~(pin_analog_mode & ~seg_pin_sel & ~pin_oe))) == 8'h00;
  endproperty
  a_ds_route: assert property (p_ds_route)
    else $error("delta-sigma routing clash");
  property p_reset_idle;
    $rose(presetn) |-> pin_oe == 8'h00 && sar_analog_input == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins not idle after reset");
endmodule : p2mx_port_properties

// File: tb/p2mx_far_model.sv
// far side model: segment driver data and pad level resolution
`timescale 1ns/100ps
module p2mx_far_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // port drive and board level
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  // resolved pads and segment data
  output logic      [7:0] pin_in,
  output logic      [7:0] lcd_segment_output
);
  // segment data moves every cycle so a stale copy shows at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lcd_segment_output <= 8'h5A;
    else
      lcd_segment_output <= lcd_segment_output + 8'h1D;
  end
  // the port wins where it drives, the board level elsewhere
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : p2mx_far_model

// File: tb/tb_p2mx_port.sv
// self-checking bench for the port two pin multiplexer
`timescale 1ns/100ps
module tb_p2mx_port;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pin_in, pin_out, pin_oe, ext_level;
  logic [7:0]  lcd_segment_output, seg_pin_sel, pin_analog_mode;
  logic [7:0]  sar_analog_input, delta_sigma_diff_pair;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        er;
  int          num_errors, check_count;
  logic [31:0] rst_val [6] = '{32'h0, 32'hFF, 32'h0, 32'hFF, 32'h0, 32'h0};
  logic [31:0] ds_exp [4] = '{32'h03, 32'h0C, 32'h10, 32'h00};

  p2mx_port dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .lcd_segment_output, .seg_pin_sel, .pin_analog_mode,
    .sar_analog_input, .delta_sigma_diff_pair);
  p2mx_far_model far (.pclk, .presetn, .pin_out, .pin_oe, .ext_level,
    .pin_in, .lcd_segment_output);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one apb transfer; only the watchdog bounds the wait for pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, e);
  endtask : rd_chk

  // leaves time for the pin registers and the pad synchroniser
  task automatic settle;
    repeat (5) @(posedge pclk);
    #1;
  endtask : settle

  task automatic stop_test;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    presetn   = 1'b0;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    ext_level = 8'h3C;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_chk(8'(i * 4), rst_val[i]);
    chk({24'h0, pin_oe}, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk({31'h0, er}, 32'h1);
    // digital port, low pins as outputs first
    wr(8'h0C, 32'h00);
    wr(8'h00, 32'hA5);
    wr(8'h04, 32'hF0);
    apb(1'b1, 8'h00, 32'hFF, 4'h0);
    rd_chk(8'h00, 32'hA5);
    settle;
    chk({24'h0, pin_oe}, 32'h0F);
    chk({28'h0, pin_out[3:0]}, 32'h5);
    rd_chk(8'h18, 32'h35);
    // pad change passes the filter and shows on the input pins
    @(posedge pclk);
    ext_level <= 8'hC0;
    settle;
    rd_chk(8'h18, 32'hC5);
    // segment overrides direction on pins 0 and 7
    wr(8'h08, 32'h81);
    settle;
    chk({24'h0, seg_pin_sel}, 32'h81);
    chk({24'h0, pin_oe}, 32'h8F);
    rd_chk(8'h18, 32'h44);
    // analog with output direction is refused
    wr(8'h08, 32'h00);
    wr(8'h0C, 32'h03);
    settle;
    chk({24'h0, pin_oe}, 32'h0C);
    chk({24'h0, pin_analog_mode}, 32'h03);
    rd_chk(8'h1C, 32'h03);
    // converters: sar on pin 5, every delta-sigma pair code
    wr(8'h04, 32'hFF);
    wr(8'h0C, 32'hFF);
    wr(8'h10, 32'h0D);
    for (int p = 0; p < 4; p++) begin
      wr(8'h14, {29'h0, 1'b1, 2'(p)});
      settle;
      chk({24'h0, delta_sigma_diff_pair}, ds_exp[p]);
      chk({24'h0, sar_analog_input}, p == 2 ? 32'h0 : 32'h20);
      rd_chk(8'h1C, p == 2 ? 32'h2000 : 32'h0);
    end
    chk({24'h0, pin_analog_mode}, 32'hFF);
    wr(8'h0C, 32'hDF);
    settle;
    chk({24'h0, sar_analog_input}, 32'h0);
    // reset in mid-run while every pin drives
    wr(8'h0C, 32'h00);
    wr(8'h04, 32'h00);
    settle;
    chk({24'h0, pin_oe}, 32'hFF);
    // enable low stalls a latch write; it lands once the enable returns
    @(posedge pclk);
    ce <= 1'b0;
    fork
      wr(8'h00, 32'h5A);
      begin
        repeat (6) @(posedge pclk);
        chk({31'h0, pready}, 32'h0);
        chk({24'h0, pin_out}, 32'hA5);
        ce <= 1'b1;
      end
    join
    settle;
    chk({24'h0, pin_out}, 32'h5A);
    @(posedge pclk);
    presetn <= 1'b0;
    settle;
    chk({24'h0, pin_oe}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h04, 32'hFF);
    rd_chk(8'h00, 32'h00);
    stop_test;
  end

  // a hang ends the run the same way
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
endmodule : tb_p2mx_port

bind p2mx_port p2mx_port_properties u_props (.pclk, .presetn, .ce, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .pin_out, .pin_oe,
  .lcd_segment_output, .seg_pin_sel, .pin_analog_mode, .sar_analog_input,
  .delta_sigma_diff_pair);
